// ---- hw/ctp_parser.sv ----
//----------------------------------------------------------------------
// ctp_parser
//----------------------------------------------------------------------
// Purpose: walk correction table sections and keep the entries
// Assumes: an upstream section filter hands whole sections, byte-wise
// Notes:   entries become visible only after a good crc
// Functional notes
// - Sections come from the transport packets of the assigned PID.
// - Only sections carrying the configured table identifier are taken.
// - Each section is parsed on its own, table split across sections.
// - The 64-bit private section header is skipped before entries.
// - Entry count byte holds entries minus one; zero means one entry.
// - Each entry opens with an 8-bit group identifier.
// - A 16-bit session identifier follows; compared with own value.
// - Session identifier is unscrambled; compare against unscrambled id.
// - Three presence flags, 2-bit slot type, 3-bit time scaling follow.
// - Signed 8-bit time correction present only when time flag set.
// - Power flag brings selector, then 7-bit power or energy ratio.
// - Signed 16-bit frequency correction, if flagged, ends the entry.
// - Entry length comes only from the three presence flags.
// - Section crc over everything, crc included, must leave zero.
// - Slot type: 00 traffic, 01 common, 10 acquisition, 11 sync.
// - Time correction is shifted left by the scaling exponent.
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module ctp_parser #(
  parameter int MAX_ENTRIES = 256,
  parameter logic [7:0] TABLE_ID_RST = 8'h00 // arbitrary default
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] secByte,
  input wire logic secValid,
  output logic secReady,
  output logic irq
);
  import ctp_pkg::*;

  localparam int IW = $clog2(MAX_ENTRIES);

  //--------------------------------------------------------------------
  // functions
  //--------------------------------------------------------------------
  function automatic logic [31:0] crcStep(input logic [31:0] c,
                                          input logic b);
    crcStep = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? CRC_POLY : 32'h00000000);
  endfunction

  // next optional field after level lvl, S_GRP meaning entry complete
  function automatic ctp_state_e nextField(input logic [2:0] f,
                                           input logic [1:0] lvl);
    if (lvl < 2'h1 && f[2]) nextField = S_TIM;
    else if (lvl < 2'h2 && f[1]) nextField = S_PSL;
    else if (lvl < 2'h3 && f[0]) nextField = S_FRQ;
    else nextField = S_GRP;
  endfunction

  function automatic logic [4:0] fieldLen(input ctp_state_e s);
    case (s)
      S_SES: fieldLen = W_SESSION;
      S_PSL: fieldLen = W_SEL;
      S_PWR: fieldLen = W_POWER;
      S_FRQ: fieldLen = W_FREQ;
      default: fieldLen = W_BYTE;
    endcase
  endfunction

  //--------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------
  logic [7:0] byteSh_reg;
  logic [3:0] bitsLeft_reg;
  ctp_state_e state_reg, state_next;
  logic [15:0] bitIdx_reg;
  logic [31:0] crc_reg;
  logic [23:0] hdrSh_reg;
  logic [15:0] fieldSh_reg;
  logic [4:0] fieldCnt_reg;
  logic [7:0] loopCnt_reg;
  logic [IW:0] entryNum_reg, relCount_reg;
  logic [IW-1:0] entrySel_reg;
  logic bank_reg, tidBad_reg, fmtBad_reg, ownSeen_reg, wrPend_reg;
  logic [7:0] eGroup_reg, eTime_reg;
  logic [15:0] eSess_reg, eFreq_reg;
  logic [2:0] eFlg_reg, eScale_reg;
  logic [1:0] eSlot_reg;
  logic ePsel_reg;
  logic [6:0] ePwr_reg;
  logic [63:0] entryMem [2*MAX_ENTRIES];
  logic ctrlEn_reg;
  logic [7:0] tableId_reg;
  logic [15:0] ownId_reg;
  logic [ST_W-1:0] status_reg, status_next, mask_reg;

  //--------------------------------------------------------------------
  // combinational decode
  //--------------------------------------------------------------------
  // byte serialiser and section position
  wire logic take = secValid & secReady;
  wire logic bitVal = bitsLeft_reg != 4'h0;
  wire logic curBit = byteSh_reg[7];
  wire logic inSec = state_reg != S_IDLE;
  wire logic idleStart = bitVal & (bitsLeft_reg == 4'h8) & ctrlEn_reg;
  wire logic proc = bitVal & (inSec | idleStart);
  wire logic [15:0] bitIdx = inSec ? bitIdx_reg : 16'h0000;
  wire logic [31:0] crcNext = crcStep(inSec ? crc_reg : CRC_INIT, curBit);
  wire logic [23:0] hdrVal = {hdrSh_reg[22:0], curBit};
  wire logic [15:0] fieldVal = {fieldSh_reg[14:0], curBit};
  wire logic fieldDone = fieldCnt_reg == 5'h01;
  // section length known once the first 24 bits are in
  wire logic [15:0] totalBits = ({4'h0, hdrSh_reg[11:0]} + LEN_BIAS) << 3;
  wire logic lenKnown = bitIdx > LEN_LAST_BIT;
  wire logic lastBit = proc & lenKnown & (bitIdx + 16'h0001 == totalBits);
  wire logic inCrc = lenKnown & (bitIdx >= totalBits - CRC_BITS);
  wire logic inEntry = state_reg != S_HDR && state_reg != S_SKIP &&
                       state_reg != S_IDLE;
  wire logic tidMiss = hdrVal[7:0] != tableId_reg;
  // section verdict on its final bit
  wire logic secGood = lastBit & (crcNext == 32'h00000000) & ~tidBad_reg &
                       ~fmtBad_reg & (state_reg == S_SKIP);
  wire logic [2:0] flgNow = fieldVal[7:5];
  wire ctp_state_e afterFlg = nextField(flgNow, 2'h0);
  wire ctp_state_e afterTim = nextField(eFlg_reg, 2'h1);
  wire ctp_state_e afterPwr = nextField(eFlg_reg, 2'h2);
  wire logic lastEntry = entryNum_reg[7:0] == loopCnt_reg;

  // field walk; entry length follows from the presence flags only
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: state_next = S_HDR;
      S_HDR: begin
        if (bitIdx == TID_LAST_BIT && tidMiss)
          state_next = S_SKIP;
        else if (bitIdx == HDR_LAST_BIT)
          state_next = S_CNT;
      end
      S_CNT: if (fieldDone) state_next = S_GRP;
      S_GRP: if (fieldDone) state_next = S_SES;
      S_SES: if (fieldDone) state_next = S_FLG;
      S_FLG: if (fieldDone) state_next = afterFlg;
      S_TIM: if (fieldDone) state_next = afterTim;
      S_PSL: state_next = S_PWR;
      S_PWR: if (fieldDone) state_next = afterPwr;
      S_FRQ: if (fieldDone) state_next = S_GRP;
      S_SKIP: state_next = S_SKIP;
    endcase
  end

  // an entry closes when the walk would return to a group byte
  wire logic entryEnd = proc & fieldDone & (state_reg != S_GRP) &
                        (state_reg != S_CNT) &
                        (state_next == S_GRP);
  wire ctp_state_e walkNext = (entryEnd && lastEntry) ? S_SKIP : state_next;

  // entry readout, applied time correction and own-id match
  wire logic [63:0] rdEntry = entryMem[{bank_reg, entrySel_reg}];
  wire logic [15:0] rdTime = 16'({{8{rdEntry[31]}}, rdEntry[31:24]}
                                 << rdEntry[26+8:32]);
  wire logic rdOwn = rdEntry[55:40] == ownId_reg;
  wire logic [63:0] wrEntry = {eGroup_reg, eSess_reg, eFlg_reg, eSlot_reg,
                               eScale_reg, eTime_reg, ePsel_reg, ePwr_reg,
                               eFreq_reg};

  // apb decode
  wire logic acc = psel & penable & ~pready;
  wire logic wr = psel & penable & pready & pwrite; // lands on completion
  wire logic selStatus = paddr == ADDR_STATUS;
  wire logic [ST_W-1:0] ev = {secGood & ownSeen_reg,
                              lastBit & ~secGood & fmtBad_reg,
                              lastBit & tidBad_reg,
                              lastBit & ~tidBad_reg & (crcNext != 32'h0),
                              secGood};
  wire logic [ST_W-1:0] clr = (wr && selStatus) ? pwdata[ST_W-1:0] : '0;
  wire logic mapped = paddr <= ADDR_ENTRY_C && paddr[1:0] == 2'h0;
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    case (paddr)
      ADDR_CTRL: rdMux[CTRL_EN] = ctrlEn_reg;
      ADDR_TABLE_ID: rdMux[7:0] = tableId_reg;
      ADDR_OWN_ID: rdMux[15:0] = ownId_reg;
      ADDR_STATUS: rdMux[ST_W-1:0] = status_reg;
      ADDR_MASK: rdMux[ST_W-1:0] = mask_reg;
      ADDR_COUNT: rdMux[IW:0] = relCount_reg;
      ADDR_ENTRY_SEL: rdMux[IW-1:0] = entrySel_reg;
      ADDR_ENTRY_A: rdMux = rdEntry[63:32];
      ADDR_ENTRY_B: rdMux = rdEntry[31:0];
      ADDR_ENTRY_C: rdMux = {15'h0000, rdOwn, rdTime};
      default: rdMux = 32'h00000000;
    endcase
  end
  // set wins over a write-one clear
  assign status_next = (status_reg & ~clr) | ev;

  //--------------------------------------------------------------------
  // byte serialiser
  //--------------------------------------------------------------------
  // one byte is taken, then shifted out msb first over eight cycles
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      byteSh_reg <= 8'h00;
      bitsLeft_reg <= 4'h0;
      secReady <= 1'b1;
    end else if (take) begin
      byteSh_reg <= secByte;
      bitsLeft_reg <= 4'h8;
      secReady <= 1'b0;
    end else if (bitVal) begin
      byteSh_reg <= {byteSh_reg[6:0], 1'b0};
      bitsLeft_reg <= bitsLeft_reg - 4'h1;
      secReady <= bitsLeft_reg == 4'h1;
    end
  end

  //--------------------------------------------------------------------
  // section walker
  //--------------------------------------------------------------------
  // position, crc and field counters; each section starts afresh
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= S_IDLE;
      bitIdx_reg <= 16'h0000;
      crc_reg <= CRC_INIT;
      hdrSh_reg <= 24'h000000;
      fieldSh_reg <= 16'h0000;
      fieldCnt_reg <= W_BYTE;
      tidBad_reg <= 1'b0;
      fmtBad_reg <= 1'b0;
    end else if (proc) begin
      bitIdx_reg <= bitIdx + 16'h0001;
      crc_reg <= crcNext;
      hdrSh_reg <= (bitIdx <= LEN_LAST_BIT) ? hdrVal : hdrSh_reg;
      fieldSh_reg <= fieldVal;
      state_reg <= lastBit ? S_IDLE : walkNext;
      if (!inSec) begin
        tidBad_reg <= 1'b0;
        fmtBad_reg <= 1'b0;
      end else begin
        if (state_reg == S_HDR && bitIdx == TID_LAST_BIT && tidMiss)
          tidBad_reg <= 1'b1;
        if (inEntry && inCrc)
          fmtBad_reg <= 1'b1;
      end
      if (fieldDone || walkNext != state_reg)
        fieldCnt_reg <= fieldLen(walkNext);
      else if (inEntry)
        fieldCnt_reg <= fieldCnt_reg - 5'h01;
    end
  end

  // field capture into the entry under assembly
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      loopCnt_reg <= 8'h00;
      eGroup_reg <= 8'h00;
      eSess_reg <= 16'h0000;
      {eFlg_reg, eSlot_reg, eScale_reg} <= 8'h00;
      {eTime_reg, ePsel_reg, ePwr_reg, eFreq_reg} <= 32'h00000000;
    end else if (proc && (fieldDone || state_reg == S_PSL)) begin
      unique case (state_reg)
        S_CNT: loopCnt_reg <= fieldVal[7:0];
        S_GRP: eGroup_reg <= fieldVal[7:0];
        S_SES: eSess_reg <= fieldVal;
        S_FLG: begin
          {eFlg_reg, eSlot_reg, eScale_reg} <= fieldVal[7:0];
          {eTime_reg, ePsel_reg, ePwr_reg, eFreq_reg} <= 32'h00000000;
        end
        S_TIM: eTime_reg <= fieldVal[7:0];
        S_PSL: ePsel_reg <= curBit;
        S_PWR: ePwr_reg <= fieldVal[6:0];
        S_FRQ: eFreq_reg <= fieldVal;
        default: eGroup_reg <= eGroup_reg;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // entry store and release
  //--------------------------------------------------------------------
  // entries fill the hidden bank; secGood, a good crc with no id or format fault, swaps banks
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wrPend_reg <= 1'b0;
      entryNum_reg <= '0;
      relCount_reg <= '0;
      bank_reg <= 1'b0;
      ownSeen_reg <= 1'b0;
    end else begin
      wrPend_reg <= entryEnd;
      if (proc && !inSec) begin
        entryNum_reg <= '0;
        ownSeen_reg <= 1'b0;
      end else if (wrPend_reg) begin
        entryNum_reg <= entryNum_reg + 1'b1;
        if (eSess_reg == ownId_reg)
          ownSeen_reg <= 1'b1;
      end
      if (secGood) begin
        bank_reg <= ~bank_reg;
        relCount_reg <= entryNum_reg;
      end
    end
  end

  // entry memory, no reset
  always_ff @(posedge core_clk) begin
    if (wrPend_reg && entryNum_reg < (IW+1)'(MAX_ENTRIES))
      entryMem[{~bank_reg, entryNum_reg[IW-1:0]}] <= wrEntry;
  end

  //--------------------------------------------------------------------
  // apb registers and interrupt
  //--------------------------------------------------------------------
  // answer one cycle into the access phase
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~mapped;
      prdata <= (acc && !pwrite) ? rdMux : 32'h00000000;
    end
  end

  // software written control
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrlEn_reg <= CTRL_EN_RST;
      tableId_reg <= TABLE_ID_RST;
      ownId_reg <= OWN_ID_RST;
      mask_reg <= MASK_RST;
      entrySel_reg <= '0;
    end else if (wr) begin
      case (paddr)
        ADDR_CTRL: ctrlEn_reg <= pwdata[CTRL_EN];
        ADDR_TABLE_ID: tableId_reg <= pwdata[7:0];
        ADDR_OWN_ID: ownId_reg <= pwdata[15:0];
        ADDR_MASK: mask_reg <= pwdata[ST_W-1:0];
        ADDR_ENTRY_SEL: entrySel_reg <= pwdata[IW-1:0];
        default: mask_reg <= mask_reg;
      endcase
    end
  end

  // sticky events and level interrupt
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= '0;
      irq <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq <= |(status_next & mask_reg);
    end
  end
endmodule // ctp_parser

// ---- hw/ctp_pkg.sv ----
//----------------------------------------------------------------------
// ctp_pkg
//----------------------------------------------------------------------
// Purpose: constants and types for the correction table parser
// Assumes: section bytes arrive MSB first, one byte per handshake
// Notes:   register offsets are byte addresses on a 32-bit APB bus
package ctp_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TABLE_ID = 8'h04;
  localparam logic [7:0] ADDR_OWN_ID = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_MASK = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;
  localparam logic [7:0] ADDR_ENTRY_SEL = 8'h18;
  localparam logic [7:0] ADDR_ENTRY_A = 8'h1c;
  localparam logic [7:0] ADDR_ENTRY_B = 8'h20;
  localparam logic [7:0] ADDR_ENTRY_C = 8'h24;
  // status and mask bit positions
  localparam int ST_OK = 0;
  localparam int ST_CRC = 1;
  localparam int ST_TID = 2;
  localparam int ST_FMT = 3;
  localparam int ST_OWN = 4;
  localparam int ST_W = 5;
  localparam int CTRL_EN = 0;
  // reset values
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [ST_W-1:0] MASK_RST = 5'h00;
  localparam logic [15:0] OWN_ID_RST = 16'h0000;
  // section framing, in bits; LEN_BIAS in bytes
  localparam logic [15:0] HDR_LAST_BIT = 16'h003f;
  localparam logic [15:0] TID_LAST_BIT = 16'h0007;
  localparam logic [15:0] LEN_LAST_BIT = 16'h0017;
  localparam logic [15:0] CRC_BITS = 16'h0020;
  localparam logic [15:0] LEN_BIAS = 16'h0003;
  // field widths of the entry loop
  localparam logic [4:0] W_BYTE = 5'h08;
  localparam logic [4:0] W_SESSION = 5'h10;
  localparam logic [4:0] W_SEL = 5'h01;
  localparam logic [4:0] W_POWER = 5'h07;
  localparam logic [4:0] W_FREQ = 5'h10;
  // mpeg-2 section crc
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  // slot type of the measured burst
  typedef enum logic [1:0] {
    SLOT_TRAFFIC = 2'h0,
    SLOT_COMMON = 2'h1,
    SLOT_ACQUISITION = 2'h2,
    SLOT_SYNC = 2'h3
  } ctp_slot_e;
  // bit walker states, gray along the walk from S_IDLE to S_FRQ; the return to S_GRP is not
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_HDR = 4'h1, S_CNT = 4'h3, S_GRP = 4'h2,
    S_SES = 4'h6, S_FLG = 4'h7, S_TIM = 4'h5, S_PSL = 4'h4,
    S_PWR = 4'hc, S_FRQ = 4'hd, S_SKIP = 4'hf
  } ctp_state_e;
endpackage

// ---- verif/ctp_parser_properties.sv ----
// Purpose: port-level properties of the correction table parser
// Assumes: one clock, reset asynchronous and active low
// Notes:   bound to every parser instance
`timescale 1ns/1ps
module ctp_parser_properties (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] secByte,
  input wire logic secValid,
  input wire logic secReady,
  input wire logic irq
);
  //--------------------------------------------------------------
  // access decode
  //--------------------------------------------------------------
  // access taken, unmapped address, completed write
  wire take = psel && penable && !pready;
  wire unmapped = (paddr > 8'h24) || (paddr[1:0] != 2'h0);
  wire wrDone = psel && pwrite && pready;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  //--------------------------------------------------------------
  // properties
  //--------------------------------------------------------------
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  a_apb_answer: assert property (take |=> pready)
    else $error("no answer one cycle after an access");
  a_ready_cause: assert property (!(psel && penable) |=> !pready)
    else $error("pready without an access");
  a_err_unmapped: assert property (take && unmapped |=> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (take && !unmapped |=> !pslverr)
    else $error("mapped access refused");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside an answer");
  a_byte_gap: assert property (
    secValid && secReady |=> !secReady [*8] ##1 secReady)
    else $error("byte pacing broken");
  a_ready_idle: assert property (!secValid && secReady |=> secReady)
    else $error("byte ready dropped while idle");
  a_irq_fall: assert property ($fell(irq) |->
    $past(wrDone, 1) || $past(wrDone, 2) || $past(wrDone, 3))
    else $error("irq fell without a register write");
  // main scenarios reached
  c_byte: cover property (secValid && secReady);
  c_refused: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule // ctp_parser_properties

bind ctp_parser ctp_parser_properties chk_u (
  .core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .secByte(secByte),
  .secValid(secValid), .secReady(secReady), .irq(irq));

// ---- verif/ctp_section_source.sv ----
// Purpose: section filter model feeding the parser section bytes
// Assumes: sections arrive whole; the crc is appended here
// Notes:   a released byte line shows the inverse of the last byte
`timescale 1ns/1ps
module ctp_section_source (
  input wire logic core_clk,
  input wire logic secReady,
  output logic [7:0] secByte,
  output logic secValid
);
  //--------------------------------------------------------------
  // byte feed
  //--------------------------------------------------------------
  initial begin
    secByte = 8'hff;
    secValid = 1'b0;
  end
  // section crc, msb first, no final inversion
  function automatic logic [31:0] crc(logic [7:0] q[$]);
    logic [31:0] c;
    c = 32'hffffffff;
    foreach (q[i]) begin
      for (int k = 7; k >= 0; k--) begin
        c = {c[30:0], 1'b0} ^ ((c[31] ^ q[i][k]) ? 32'h04c11db7 : 32'h0);
      end
    end
    return c;
  endfunction
  // one section from the assigned stream; bad corrupts the crc
  task automatic send_sec(logic [7:0] q[$], bit bad);
    logic [31:0] c;
    c = crc(q);
    if (bad) c = ~c;
    for (int i = 3; i >= 0; i--) q.push_back(c[8*i +: 8]);
    foreach (q[i]) begin
      secByte <= q[i];
      secValid <= 1'b1;
      do @(posedge core_clk); while (secReady !== 1'b1);
    end
    secValid <= 1'b0;
    secByte <= ~q[q.size()-1];
  endtask
endmodule // ctp_section_source

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench of the correction table parser
// Assumes: reads are queued and judged when the answer appears
// Notes:   random fields come from an xorshift seeded with 71
`timescale 1ns/1ps
module tb_top;
  import ctp_pkg::*;
  //--------------------------------------------------------------
  // signals
  //--------------------------------------------------------------
  localparam logic [7:0] TID = 8'h41; // arbitrary table identifier
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, secValid, secReady, irq;
  logic [7:0] secByte;
  int miscompares = 0;
  int checks = 0;
  logic [32:0] expQ[$];
  logic [31:0] seed = 32'h47;
  bit bq[$];
  logic [7:0] sec[$];
  logic [31:0] ea[5], eb[5], ec[5];
  logic [15:0] own;
  always #50 core_clk = ~core_clk;
  ctp_parser dut_u (.core_clk(core_clk), .resetn(resetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .secByte(secByte), .secValid(secValid), .secReady(secReady));
  ctp_section_source src_u (.core_clk(core_clk), .secReady(secReady),
    .secByte(secByte), .secValid(secValid));
  //--------------------------------------------------------------
  // tasks and sequence
  //--------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(string nm, logic [32:0] seen, logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
    int n;
    @(posedge core_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) miscompares++; // an answer that never came fails
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(logic [7:0] a, logic [32:0] e);
    expQ.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask
  // read answers judged against the oldest note
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (expQ.size() == 0) check("read", 33'h1, 33'h0);
      else check("read", {pslverr, prdata}, expQ.pop_front());
    end
  end
  task automatic wait_irq(logic e);
    int n;
    n = 0;
    while (irq !== e && n < 40) begin @(posedge core_clk); n++; end
    check("irq", {32'h0, irq}, {32'h0, e});
  endtask
  task automatic put(logic [15:0] v, int w);
    for (int i = w - 1; i >= 0; i--) bq.push_back(v[i]);
  endtask
  // one entry packed to bits, expected register images noted
  task automatic entry(int i, bit t, bit p, bit s, bit f, logic [1:0] sl,
      logic [2:0] sc);
    logic [31:0] a, b;
    logic [15:0] ses, fc;
    logic [7:0] tc;
    logic [6:0] pw;
    a = rnd();
    b = rnd();
    ses = (i == 3) ? own : a[23:8];
    tc = t ? b[7:0] : 8'h0;
    pw = p ? b[14:8] : 7'h0;
    fc = f ? b[31:16] : 16'h0;
    put({8'h0, a[31:24]}, 8);
    put(ses, 16);
    put({8'h0, t, p, f, sl, sc}, 8);
    if (t) put({8'h0, tc}, 8);
    if (p) put({8'h0, s, pw}, 8);
    if (f) put(fc, 16);
    ea[i] = {a[31:24], ses, t, p, f, sl, sc};
    eb[i] = {tc, s & p, pw, fc};
    ec[i] = {15'h0, ses == own, 16'({{8{tc[7]}}, tc} << sc)};
  endtask
  // header, count, padded entries; crc added by the source
  task automatic section(logic [7:0] tid, logic [7:0] cnt, bit bad);
    logic [11:0] len;
    logic [7:0] b;
    while (bq.size() % 8 != 0) bq.push_back(1'b0);
    len = 12'(bq.size() / 8 + 10);
    r = rnd();
    sec = {tid, 8'(len[11:8]), len[7:0], r[7:0], r[15:8], r[23:16],
      r[31:24], 8'h00, cnt - 8'h1};
    while (bq.size() != 0) begin
      for (int k = 7; k >= 0; k--) b[k] = bq.pop_front();
      sec.push_back(b);
    end
    src_u.send_sec(sec, bad);
  endtask
  task automatic finish_test();
    if (expQ.size() != 0) miscompares++;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (30000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    resetn <= 1'b1;
    rd(ADDR_CTRL, 33'h1);
    rd(ADDR_TABLE_ID, 33'h0);
    rd(ADDR_OWN_ID, 33'h0);
    rd(ADDR_STATUS, 33'h0);
    rd(ADDR_MASK, 33'h0);
    rd(ADDR_COUNT, 33'h0);
    rd(ADDR_ENTRY_SEL, 33'h0);
    rd(8'h28, 33'h100000000);
    rd(8'h06, 33'h100000000);
    r = rnd();
    own = r[15:0];
    wr(ADDR_TABLE_ID, {24'h0, TID});
    wr(ADDR_OWN_ID, {16'h0, own});
    wr(ADDR_MASK, 32'h1f);
    rd(ADDR_MASK, 33'h1f);
    entry(0, 1, 1, 1, 1, 2'h0, 3'h2);
    entry(1, 0, 0, 0, 0, 2'h1, 3'h0);
    entry(2, 1, 1, 0, 0, 2'h2, 3'h7);
    entry(3, 0, 0, 0, 1, 2'h3, 3'h0);
    section(TID, 8'h4, 1'b0);
    wait_irq(1'b1);
    rd(ADDR_STATUS, 33'h11);
    rd(ADDR_COUNT, 33'h4);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_ENTRY_SEL, 32'(i));
      rd(ADDR_ENTRY_A, {1'b0, ea[i]});
      rd(ADDR_ENTRY_B, {1'b0, eb[i]});
      rd(ADDR_ENTRY_C, {1'b0, ec[i]});
    end
    wr(ADDR_STATUS, 32'h1f);
    wait_irq(1'b0);
    // corrupted crc on a one-entry section keeps the old release
    entry(4, 1, 0, 0, 0, 2'h2, 3'h1);
    section(TID, 8'h1, 1'b1);
    wait_irq(1'b1);
    rd(ADDR_STATUS, 33'h2);
    rd(ADDR_COUNT, 33'h4);
    rd(ADDR_ENTRY_C, {1'b0, ec[3]});
    wr(ADDR_STATUS, 32'h1f);
    entry(0, 1, 0, 0, 0, 2'h2, 3'h1);
    section(TID, 8'h1, 1'b0);
    wait_irq(1'b1);
    rd(ADDR_COUNT, 33'h1);
    wr(ADDR_ENTRY_SEL, 32'h0);
    rd(ADDR_ENTRY_C, {1'b0, ec[0]});
    wr(ADDR_STATUS, 32'h1f);
    // foreign table identifier while masked, then unmasked
    wr(ADDR_MASK, 32'h0);
    entry(4, 0, 0, 0, 0, 2'h0, 3'h0);
    section(TID ^ 8'hff, 8'h1, 1'b0);
    repeat (12) @(posedge core_clk);
    rd(ADDR_STATUS, 33'h4);
    check("irq", {32'h0, irq}, 33'h0);
    wr(ADDR_MASK, 32'h4);
    wait_irq(1'b1);
    rd(ADDR_COUNT, 33'h1);
    // one entry too few runs into the crc, then a disabled parser
    wr(ADDR_STATUS, 32'h1f);
    entry(4, 0, 0, 0, 0, 2'h1, 3'h0);
    section(TID, 8'h2, 1'b0);
    repeat (12) @(posedge core_clk);
    rd(ADDR_STATUS, 33'h8);
    rd(ADDR_COUNT, 33'h1);
    wr(ADDR_STATUS, 32'h1f);
    wr(ADDR_CTRL, 32'h0);
    section(TID, 8'h1, 1'b0);
    repeat (12) @(posedge core_clk);
    rd(ADDR_STATUS, 33'h0);
    wr(ADDR_CTRL, 32'h1);
    finish_test();
  end
endmodule // tb_top
